// ===== rtl/psir_pkg.sv
// Package for the management status and identity register bank.
// Assumes a 16-bit management register space reached over MDC/MDIO.
package psir_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [4:0] OFF_BASIC_STATUS = 5'h01;
  localparam logic [4:0] OFF_IDENTIFIER_HIGH = 5'h02;
  localparam logic [4:0] OFF_IDENTIFIER_LOW_MODEL_REV = 5'h03;
  // ==========================================================
  // Status reset value and bit positions
  localparam logic [15:0] BASIC_STATUS_RESET = 16'h7849;
  localparam int BIT_T4 = 15;
  localparam int BIT_TX_FD = 14;
  localparam int BIT_TX_HD = 13;
  localparam int BIT_T_FD = 12;
  localparam int BIT_T_HD = 11;
  localparam int BIT_NO_PREAMBLE = 6;
  localparam int BIT_AN_DONE = 5;
  localparam int BIT_REMOTE_FAULT = 4;
  localparam int BIT_AN_ABLE = 3;
  localparam int BIT_LINK = 2;
  localparam int BIT_JABBER = 1;
  localparam int BIT_EXT_CAP = 0;
  // ==========================================================
  // Identifier field layout
  localparam int ID_OUI_LOW_POS = 10;
  localparam int ID_MODEL_POS = 4;
  localparam int ID_REV_POS = 0;
  // ==========================================================
  // Frame constants
  localparam int PREAMBLE_BITS = 32;
  localparam logic [1:0] FRAME_START = 2'b01;
  localparam logic [1:0] OP_READ = 2'b10;
  localparam logic [1:0] OP_WRITE = 2'b01;
  localparam int FRAME_HDR_BITS = 14;
  localparam int FRAME_DATA_BITS = 16;
  // ==========================================================
  // Timing
  localparam int IDLE_GAP_NS = 500;
  localparam int CLK_SYS_NS = 10;
  localparam int IDLE_GAP_CYCLES = (IDLE_GAP_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;

  typedef struct packed {
    logic anDone;
    logic farFault;
    logic link;
    logic jabber;
    logic speed10;
  } psir_phy_stat_t;

  typedef struct packed {
    logic valid;
    logic isWrite;
    logic [4:0] regAddr;
  } psir_req_t;
endpackage : psir_pkg

// ===== rtl/psir_regs.sv
// Status and identity register bank behind an MDC/MDIO serial port.
// Assumes MDC arrives as its own clock and PHY state levels are async.
// The host keeps MDC still outside frames; reset is held across MDC edges.
//
// Behaviour
// - Status at offset one, reset 0x7849
// - Bit 15 four-pair ability always zero
// - Bits 14 to 11 abilities read one
// - Bit 6 preamble suppression capable reads one
// - Preamble needed only after reset or error
// - Bit 5 shows auto-negotiation finished
// - Bit 4 far fault, cleared on read
// - Bit 3 auto-negotiation ability reads one
// - Bit 2 shows valid link status
// - Bit 1 jabber, meaningful at 10 Mbps
// - Bit 0 extended capability reads one
// - Identifier high holds OUI bits 21:6
// - Identifier low bits 15:10 OUI 5:0
// - Identifier low bits 9:4 model number
// - Identifier low bits 3:0 revision number
`timescale 1ns/1ns
module psir_regs #(
  // Arbitrary identity values, not of any real part
  parameter logic [15:0] OUI_HIGH = 16'h1234,
  parameter logic [5:0] OUI_LOW = 6'h15,
  parameter logic [5:0] MODEL_NUM = 6'h0a,
  parameter logic [3:0] REV_NUM = 4'h3,
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic mdcClk,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  input wire psir_pkg::psir_phy_stat_t phyStat,
  output logic readStrobe
);
  import psir_pkg::*;

  // ==========================================================
  // Link-state inputs into the system domain
  logic anDoneSync;
  logic faultSync;
  logic linkSync;
  logic jabberSync;
  logic speed10Sync;
  logic [4:0] statIn;
  logic [4:0] statSync;

  assign statIn = {phyStat.anDone, phyStat.farFault, phyStat.link,
                   phyStat.jabber, phyStat.speed10};

  for (genvar g = 0; g < 5; g++) begin : gSync
    psir_sync3 uSync (
      .clk(clk_sys),
      .rst(rst),
      .ce(ce),
      .din(statIn[g]),
      .dout(statSync[g])
    );
  end
  assign {anDoneSync, faultSync, linkSync, jabberSync, speed10Sync} = statSync;

  // ==========================================================
  // Sticky far-end fault; set wins over read clear
  // A fault still present re-sets the bit in the cycle of the clear
  logic farFault;
  logic rdClear;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      farFault <= BASIC_STATUS_RESET[BIT_REMOTE_FAULT];
    end else if (ce) begin
      if (faultSync) begin
        farFault <= 1'b1;
      end else if (rdClear) begin
        farFault <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Status word assembly
  function automatic logic [15:0] status_word(input logic an, input logic rf,
                                              input logic lk, input logic jb);
    logic [15:0] w;
    w = BASIC_STATUS_RESET;
    w[BIT_T4] = 1'b0;
    w[BIT_TX_FD] = 1'b1;
    w[BIT_TX_HD] = 1'b1;
    w[BIT_T_FD] = 1'b1;
    w[BIT_T_HD] = 1'b1;
    w[10:7] = 4'h0;
    w[BIT_NO_PREAMBLE] = 1'b1;
    w[BIT_AN_DONE] = an;
    w[BIT_REMOTE_FAULT] = rf;
    w[BIT_AN_ABLE] = 1'b1;
    w[BIT_LINK] = lk;
    w[BIT_JABBER] = jb;
    w[BIT_EXT_CAP] = 1'b1;
    return w;
  endfunction : status_word

  logic [15:0] basicStatus;
  logic [15:0] identifierHigh;
  logic [15:0] identifierLowModelRev;

  // Jabber only has meaning at 10 Mbps
  assign basicStatus = status_word(anDoneSync, farFault, linkSync,
                                   jabberSync & speed10Sync);
  assign identifierHigh = OUI_HIGH;
  assign identifierLowModelRev = {OUI_LOW, MODEL_NUM, REV_NUM};

  // ==========================================================
  // Read-data snapshot, handed to MDC domain by timing after a toggle request
  logic reqTog;
  logic reqTogS1;
  logic reqTogS2;
  logic reqTogS3;
  logic [4:0] reqAddrSys;
  logic [15:0] rdData;
  logic reqSeenD;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reqTogS1 <= 1'b0;
      reqTogS2 <= 1'b0;
      reqTogS3 <= 1'b0;
    end else if (ce) begin
      reqTogS1 <= reqTog;
      reqTogS2 <= reqTogS1;
      reqTogS3 <= reqTogS2;
    end
  end

  logic reqSeen;
  assign reqSeen = reqTogS2 != reqTogS3;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdData <= 16'h0000;
      rdClear <= 1'b0;
      readStrobe <= 1'b0;
    end else if (ce) begin
      rdClear <= 1'b0;
      readStrobe <= 1'b0;
      // Served one cycle after the edge, once the address has been taken
      if (reqSeenD) begin
        readStrobe <= 1'b1;
        case (reqAddrSys)
          OFF_BASIC_STATUS: begin
            rdData <= basicStatus;
            rdClear <= 1'b1;
          end
          OFF_IDENTIFIER_HIGH: rdData <= identifierHigh;
          OFF_IDENTIFIER_LOW_MODEL_REV: rdData <= identifierLowModelRev;
          default: rdData <= 16'h0000;
        endcase
      end
    end
  end

  // ==========================================================
  // MDC-domain serial frame engine
  typedef enum {
    ST_IDLE,
    ST_PRE,
    ST_START,
    ST_HDR,
    ST_TA,
    ST_DATA,
    ST_WRITE
  } psir_state_t;

  psir_state_t state;
  logic [5:0] bitCnt;
  logic [13:0] hdr;
  logic [15:0] shiftOut;
  logic preambleOk;
  logic [4:0] regAddrMdc;
  logic startBit;

  // Address crosses as a word held stable while the toggle travels;
  // it is taken on the last two stages only, never on the first
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reqSeenD <= 1'b0;
      reqAddrSys <= 5'h00;
    end else if (ce) begin
      reqSeenD <= reqSeen;
      if (reqSeen) begin
        reqAddrSys <= regAddrMdc;
      end
    end
  end

  // ==========================================================
  // Opcode decode used by the first turnaround check
  function automatic logic op_known(input logic [1:0] op);
    return op == OP_READ || op == OP_WRITE;
  endfunction : op_known

  // Frame on MDIO, sampled on MDC rise:
  //   idle ones, start 01, opcode, PHY address, register, turnaround, data
  //   read: device drives the second turnaround bit low, then 16 bits MSB first
  //   write: host drives turnaround 10; data shifted in and dropped
  // Read data is copied from the system domain at the second
  // turnaround edge: the system side settles it within four clk_sys edges, under 40 ns,
  // well inside one 80 ns MDC period, and holds it until the next request.
  // Limitation: with ce held low during a read the word comes back stale.

  // ==========================================================
  // Frame engine

  // The MDC clock may stop between frames; state waits on next frame
  always_ff @(posedge mdcClk) begin
    if (rst) begin
      state <= ST_IDLE;
      bitCnt <= 6'd0;
      hdr <= 14'h0000;
      preambleOk <= 1'b0;
      reqTog <= 1'b0;
      regAddrMdc <= 5'h00;
      startBit <= 1'b0;
      shiftOut <= 16'h0000;
      mdioOe <= 1'b0;
      mdioOut <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          // Idle high edges also count toward a fresh preamble
          mdioOe <= 1'b0;
          if (mdioIn) begin
            bitCnt <= 6'(bitCnt + 6'd1);
            if (bitCnt >= 6'(PREAMBLE_BITS - 1)) begin
              preambleOk <= 1'b1;
            end
            // One idle high edge between frames suffices after first preamble
            state <= ST_PRE;
          end
        end
        ST_PRE: begin
          if (mdioIn) begin
            if (bitCnt != 6'h3f) begin
              bitCnt <= 6'(bitCnt + 6'd1);
            end
            if (bitCnt >= 6'(PREAMBLE_BITS - 1)) begin
              preambleOk <= 1'b1;
            end
          end else if (preambleOk) begin
            state <= ST_START;
          end else begin
            bitCnt <= 6'd0;
            state <= ST_IDLE;
          end
        end
        ST_START: begin
          bitCnt <= 6'd0;
          if (mdioIn) begin
            state <= ST_HDR;
          end else begin
            state <= ST_IDLE;
          end
        end
        ST_HDR: begin
          hdr <= {hdr[12:0], mdioIn};
          bitCnt <= 6'(bitCnt + 6'd1);
          if (bitCnt == 6'(FRAME_HDR_BITS - 3)) begin
            state <= ST_TA;
            bitCnt <= 6'd0;
            regAddrMdc <= {hdr[3:0], mdioIn};
            startBit <= 1'b0;
          end
        end
        ST_TA: begin
          // hdr now holds op(2) phy(5) reg(5)
          if (!op_known(hdr[11:10])) begin
            preambleOk <= 1'b0;
            state <= ST_IDLE;
            bitCnt <= 6'd0;
          end else if (hdr[11:10] == OP_WRITE) begin
            if (!startBit) begin
              startBit <= 1'b1;
              if (!mdioIn) begin
                preambleOk <= 1'b0;
                state <= ST_IDLE;
                bitCnt <= 6'd0;
              end
            end else if (mdioIn) begin
              // Second turnaround bit high: invalid, full preamble again
              preambleOk <= 1'b0;
              state <= ST_IDLE;
              bitCnt <= 6'd0;
            end else begin
              state <= ST_WRITE;
              bitCnt <= 6'd0;
            end
          end else if (hdr[9:5] != PHY_ADDR) begin
            // Other address: stay off the wire through turnaround and data
            state <= ST_WRITE;
            bitCnt <= 6'h3f;
          end else if (!startBit) begin
            startBit <= 1'b1;
            reqTog <= ~reqTog;
            mdioOe <= 1'b1;
            mdioOut <= 1'b0;
          end else begin
            shiftOut <= {rdData[14:0], 1'b0};
            mdioOut <= rdData[15];
            state <= ST_DATA;
            bitCnt <= 6'd1;
          end
        end
        ST_DATA: begin
          // Drive ends after the last bit, before the next idle edge
          mdioOut <= shiftOut[15];
          shiftOut <= {shiftOut[14:0], 1'b0};
          bitCnt <= 6'(bitCnt + 6'd1);
          if (bitCnt == 6'(FRAME_DATA_BITS)) begin
            mdioOe <= 1'b0;
            state <= ST_IDLE;
            bitCnt <= 6'd0;
          end
        end
        ST_WRITE: begin
          // Data shifted in and dropped: registers are read only
          bitCnt <= 6'(bitCnt + 6'd1);
          if (bitCnt == 6'(FRAME_DATA_BITS - 1)) begin
            state <= ST_IDLE;
            bitCnt <= 6'd0;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule : psir_regs

// ===== rtl/psir_sync3.sv
// Three-stage synchroniser for a level coming from another domain.
// The output itself waits for stages two and three to agree before it follows.
`timescale 1ns/1ns
module psir_sync3 (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic din,
  output logic dout
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      dout <= 1'b0;
    end else if (ce) begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      // Change counts once two later stages agree
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule : psir_sync3

// ===== verif/psir_regs_asserts.sv
// Checker on the ports of the status and identity bank.
// Assumes PHY address one and MDIO sampled on MDC rise.
`timescale 1ns/1ns
module psir_regs_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic mdcClk,
  input wire logic mdioIn,
  input wire logic mdioOut,
  input wire logic mdioOe,
  input wire logic readStrobe
);
  import psir_pkg::*;
  logic [4:0] oeCnt;
  // ========
  // Drive window length, MDC stops between frames
  always_ff @(posedge mdcClk) begin
    if (rst) oeCnt <= 5'h00;
    else oeCnt <= mdioOe ? oeCnt + 5'h01 : 5'h00;
  end
  a_oe_reset: assert property (@(posedge mdcClk) rst |=> !mdioOe)
    else $error("drive after reset");
  a_ta_low: assert property (@(posedge mdcClk) disable iff (rst)
    $rose(mdioOe) |-> !mdioOut) else $error("turnaround not low");
  a_read_only: assert property (@(posedge mdcClk) disable iff (rst)
    $rose(mdioOe) |-> $past(mdioIn, 13) && !$past(mdioIn, 12)) else $error("not a read");
  a_own_addr: assert property (@(posedge mdcClk) disable iff (rst)
    $rose(mdioOe) |-> $past(mdioIn, 7) && !$past(mdioIn, 8)) else $error("wrong address");
  a_oe_hold: assert property (@(posedge mdcClk) disable iff (rst)
    $rose(mdioOe) |=> mdioOe [*8]) else $error("drive cut short");
  a_word_len: assert property (@(posedge mdcClk) disable iff (rst)
    $fell(mdioOe) |-> oeCnt == 5'h11) else $error("word length");
  a_t4_zero: assert property (@(posedge mdcClk) disable iff (rst)
    $rose(mdioOe) && !$past(mdioIn, 3) && $past(mdioIn, 2) |=> !mdioOut)
    else $error("top status bit set");
  a_ext_cap: assert property (@(posedge mdcClk) disable iff (rst)
    $fell(mdioOe) && $past(mdioIn, 19) && !$past(mdioIn, 20) |-> $past(mdioOut))
    else $error("status bit zero clear");
  a_strobe_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    readStrobe |=> !readStrobe) else $error("strobe too long");
  a_strobe_reset: assert property (@(posedge clk_sys) rst |=> !readStrobe)
    else $error("strobe in reset");
  c_strobe: cover property (@(posedge clk_sys) readStrobe);
  c_word: cover property (@(posedge mdcClk) $fell(mdioOe));
  c_release: cover property (@(posedge clk_sys) rst ##1 !rst);
endmodule : psir_regs_asserts

bind psir_regs psir_regs_asserts i_chk (.clk_sys(clk_sys), .rst(rst), .mdcClk(mdcClk),
  .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe), .readStrobe(readStrobe));

// ===== verif/psir_regs_bench.sv
// Self-checking bench for the status and identity bank.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/1ns
`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin badCount++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module psir_regs_bench;
  import psir_pkg::*;
  // Arbitrary identity values
  localparam logic [15:0] OUI_HI = 16'h5a3c;
  localparam logic [5:0] OUI_LO = 6'h2d;
  localparam logic [5:0] MODEL = 6'h11;
  localparam logic [3:0] REV = 4'h6;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic mdcClk, mdioIn, mdioOut, mdioOe, readStrobe, ta;
  logic [15:0] rd;
  psir_phy_stat_t phyStat = '0;
  int badCount = 0;
  int cmpCount = 0;
  int cycles = 0;
  int strobeCount = 0;
  // Strobe counted on the falling edge after the rising edge that launches it
  always @(negedge clk_sys) begin
    if (readStrobe === 1'b1) begin
      strobeCount++;
    end
  end
  // ========
  // Design and host
  psir_regs #(.OUI_HIGH(OUI_HI), .OUI_LOW(OUI_LO), .MODEL_NUM(MODEL), .REV_NUM(REV),
    .PHY_ADDR(5'h01)) i_dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .mdcClk(mdcClk),
    .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe), .phyStat(phyStat),
    .readStrobe(readStrobe));
  psir_smc_model i_host (.mdc(mdcClk), .mdioWire(mdioIn), .mdioOut(mdioOut),
    .mdioOe(mdioOe));
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      badCount++;
      completeRun();
    end
  end
  task automatic completeRun;
    $display("compares %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : completeRun
  task automatic rd_chk(input bit pre, input logic [4:0] ra, input logic [15:0] exp);
    int n;
    n = strobeCount;
    i_host.xfer(pre, OP_READ, ra, 16'h0000, rd, ta);
    `CHK(ta, 1'b0)
    `CHK(rd, exp)
    `CHK(strobeCount, n + 1)
  endtask : rd_chk
  task automatic set_stat(input logic [4:0] v);
    @(negedge clk_sys);
    phyStat = v;
  endtask : set_stat
  task automatic t_ident;
    rd_chk(1'b0, OFF_IDENTIFIER_HIGH, OUI_HI);
    rd_chk(1'b0, OFF_IDENTIFIER_LOW_MODEL_REV, {OUI_LO, MODEL, REV});
  endtask : t_ident
  task automatic t_live;
    set_stat(5'b10111);
    rd_chk(1'b0, OFF_BASIC_STATUS, 16'h786f);
    set_stat(5'b10110);
    rd_chk(1'b0, OFF_BASIC_STATUS, 16'h786d);
    set_stat(5'b00000);
    rd_chk(1'b0, OFF_BASIC_STATUS, 16'h7849);
  endtask : t_live
  task automatic t_fault;
    set_stat(5'b01000);
    repeat (10) @(negedge clk_sys);
    set_stat(5'b00000);
    rd_chk(1'b0, OFF_BASIC_STATUS, 16'h7859);
    rd_chk(1'b0, OFF_BASIC_STATUS, 16'h7849);
  endtask : t_fault
  task automatic t_write;
    int n;
    n = strobeCount;
    i_host.xfer(1'b0, OP_WRITE, OFF_BASIC_STATUS, 16'hffff, rd, ta);
    i_host.xfer(1'b0, OP_WRITE, OFF_IDENTIFIER_HIGH, 16'h0000, rd, ta);
    `CHK(strobeCount, n)
    rd_chk(1'b0, OFF_BASIC_STATUS, 16'h7849);
    rd_chk(1'b0, OFF_IDENTIFIER_HIGH, OUI_HI);
  endtask : t_write
  task automatic t_bad_op;
    i_host.xfer(1'b0, 2'b11, OFF_BASIC_STATUS, 16'h0000, rd, ta);
    i_host.xfer(1'b0, OP_READ, OFF_BASIC_STATUS, 16'h0000, rd, ta);
    `CHK(i_host.answered, 1'b0)
    rd_chk(1'b1, OFF_BASIC_STATUS, 16'h7849);
  endtask : t_bad_op
  initial begin
    // MDC must tick while reset is held
    fork
      repeat (16) @(negedge clk_sys);
      i_host.idle(2);
    join
    @(negedge clk_sys);
    rst = 1'b0;
    rd_chk(1'b1, OFF_BASIC_STATUS, BASIC_STATUS_RESET);
    rd_chk(1'b0, OFF_BASIC_STATUS, 16'h7849);
    t_ident();
    t_live();
    t_fault();
    t_write();
    t_bad_op();
    completeRun();
  end
endmodule : psir_regs_bench

// ===== verif/psir_smc_model.sv
// Station management controller model driving MDC and MDIO.
// Assumes a pull-up on MDIO; frames are started by the bench.
`timescale 1ns/1ns
module psir_smc_model (
  output logic mdc,
  output logic mdioWire,
  input wire logic mdioOut,
  input wire logic mdioOe
);
  logic hostOe = 1'b0;
  logic hostBit = 1'b1;
  logic answered = 1'b0;
  initial mdc = 1'b0;
  // ========
  // Wire level: device, host or pull-up
  assign mdioWire = mdioOe ? mdioOut : (hostOe ? hostBit : 1'b1);
  task automatic slot(input logic drv, input logic b, output logic s);
    hostOe = drv;
    hostBit = b;
    #39 s = mdioWire;
    answered = answered | mdioOe;
    #1 mdc = 1'b1;
    #40 mdc = 1'b0;
  endtask : slot
  task automatic idle(input int n);
    logic s;
    repeat (n) slot(1'b0, 1'b1, s);
  endtask : idle
  task automatic xfer(input bit pre, input logic [1:0] op, input logic [4:0] ra,
    input logic [15:0] wd, output logic [15:0] rd, output logic ta);
    logic [13:0] h;
    logic s;
    h = {2'b01, op, 5'h01, ra};
    answered = 1'b0;
    // Odd offset keeps MDC unrelated to clk_sys
    #603;
    repeat (pre ? 32 : 1) slot(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) slot(1'b1, h[i], s);
    if (op == 2'b10) begin
      slot(1'b0, 1'b0, s);
      slot(1'b0, 1'b0, ta);
      for (int i = 15; i >= 0; i--) slot(1'b0, 1'b0, rd[i]);
    end else begin
      slot(1'b1, 1'b1, s);
      slot(1'b1, 1'b0, ta);
      for (int i = 15; i >= 0; i--) slot(1'b1, wd[i], s);
    end
    hostOe = 1'b0;
  endtask : xfer
endmodule : psir_smc_model
